// File: rtl/irc_pkg.sv
package irc_pkg;

  // Register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_CMDPTR = 4'h4;
  localparam logic [3:0] REG_INTEV  = 4'h8;

  // Control register bit positions
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_FILL   = 1;
  localparam int CTRL_KEEP   = 2;
  localparam int CTRL_MULTI  = 3;
  localparam int CTRL_EVT_LO = 8;
  localparam int CTRL_ACTIVE = 15;

  // Interrupt event register bit positions
  localparam int INT_CTX   = 0;
  localparam int INT_FATAL = 1;

  // Reset values
  localparam logic [27:0] CMDPTR_RST = 28'h0000000;
  localparam logic [4:0]  EVT_RST    = 5'h00;

  // Event and completion codes
  localparam logic [4:0] EVT_LONG_PKT   = 5'h02;
  localparam logic [4:0] EVT_OVERRUN    = 5'h05;
  localparam logic [4:0] EVT_DESC_READ  = 5'h06;
  localparam logic [4:0] EVT_DATA_WRITE = 5'h08;
  localparam logic [4:0] EVT_UNKNOWN    = 5'h0E;
  localparam logic [4:0] EVT_COMPLETE   = 5'h11;
  localparam logic [4:0] EVT_DATA_ERR   = 5'h1D;

  localparam logic [1:0] IFLAG_ALWAYS = 2'h3;
  localparam logic [3:0] BLOCK_END    = 4'h0;
  localparam logic [27:0] DESC_STEP   = 28'h0000001;

  typedef struct packed {
    logic [27:0] addr;
    logic        last;
    logic        s;
    logic [1:0]  i;
    logic [3:0]  z;
    logic [27:0] next_program_pointer;
  } irc_desc_t;

  typedef struct packed {
    logic [27:0] addr;
    logic [4:0]  transfer_status_field;
    logic [15:0] residual_count_field;
  } irc_sts_t;

  typedef struct packed {
    logic [15:0] data_len;
    logic [1:0]  tag;
    logic [5:0]  channel_number;
    logic [3:0]  tcode;
    logic [3:0]  sync_field;
  } irc_hdr_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_RUN   = 3'b010,
    ST_I1    = 3'b011,
    ST_I2    = 3'b100,
    ST_I3    = 3'b101
  } irc_state_t;

endpackage : irc_pkg

// File: rtl/irc_completion.sv
`timescale 1ns/1ps
// Overview of operation
// - Bus error while fetching the program reports code 06h.
// - Unprocessable program, or multi-channel with bad mode, reports 0Eh.
// - Bus error while writing packet data to memory reports 08h.
// - Receive FIFO full during a packet reports overrun 05h.
// - Data CRC or data length error reports 1Dh.
// - Last-input descriptor exhausted before packet end reports 02h.
// - Packet stored completely without error reports 11h.
// - First handling step writes the code into the context event field.
// - Buffer-fill mode always writes status and residual count back.
// - Packet-per-buffer writes status only when descriptor s flag is set.
// - After status, go to error step on 06h, 0Eh, 08h or 05h, else normal step.
// - Error step sets global fatal flag when i flag is 11b.
// - Error step loads failing descriptor address into command pointer.
// - Normal step sets context interrupt bit when i flag is 11b.
// - Block count 0 returns to idle, else branch and fetch next.
// - Fill-mode select bit cleared selects packet-per-buffer mode.
// - More-input holding whole packet skips the last-input descriptor.
// - Status goes to whichever descriptor completed the packet.
// - Packet larger than its program stores what fits, reports long.
// - Header-keep cleared strips header and trailer and aligns writes.
// - Kept header in packet-per-buffer aligns only when header split.
// - Stored header holds length, tag, channel, tcode and sync fields.
// - Buffer-fill residual count reaching 0 enters interrupt handling.
module irc_completion (
  // Clock and reset
  input  wire logic                I_CLK,
  input  wire logic                I_RST_N,
  // Register port
  input  wire logic [3:0]          I_ADDR,
  input  wire logic [31:0]         I_WDATA,
  input  wire logic                I_WR,
  input  wire logic                I_RD,
  output logic [31:0]              O_RDATA,
  // Program fetch
  output logic                     O_FETCH_REQ,
  output logic [27:0]              O_FETCH_ADDR,
  input  wire logic                I_FETCH_ERR,
  input  wire logic                I_DESC_VALID,
  input  wire irc_pkg::irc_desc_t  I_DESC,
  input  wire logic                I_PROG_ERR,
  // Packet store progress
  input  wire logic                I_WR_ERR,
  input  wire logic                I_FIFO_FULL,
  input  wire logic                I_PKT_DONE,
  input  wire logic                I_PKT_BAD,
  input  wire logic                I_BUF_EMPTY,
  input  wire logic [15:0]         I_RES_CNT,
  input  wire logic                I_HDR_SPLIT,
  input  wire logic                I_HDR_VALID,
  input  wire logic [31:0]         I_HDR,
  // Status and stream controls
  output logic                     O_STS_WR,
  output irc_pkg::irc_sts_t        O_STS,
  output irc_pkg::irc_hdr_t        O_HDR,
  output logic                     O_STRIP,
  output logic                     O_ALIGN,
  output logic                     O_ACTIVE,
  output logic [1:0]               O_INT_EVENTS
);

  function automatic logic evt_is_error(input logic [4:0] c);
    evt_is_error = (c == irc_pkg::EVT_DESC_READ) ||
                   (c == irc_pkg::EVT_UNKNOWN) ||
                   (c == irc_pkg::EVT_DATA_WRITE) ||
                   (c == irc_pkg::EVT_OVERRUN);
  endfunction : evt_is_error

  irc_pkg::irc_state_t st_q;
  irc_pkg::irc_desc_t  cur_q;
  logic [4:0]          evt_q;
  logic [4:0]          evt_field_q;
  logic [27:0]         cmdptr_q;
  logic [27:0]         err_addr_q;
  logic [15:0]         res_q;
  logic                fill_q;
  logic                keep_q;
  logic                multi_q;
  logic [1:0]          int_q;
  logic                start;
  logic                ppb;
  logic                ctrl_wr;

  assign ctrl_wr = I_WR && (I_ADDR == irc_pkg::REG_CTRL);
  assign start   = ctrl_wr && I_WDATA[irc_pkg::CTRL_RUN] &&
                   (st_q == irc_pkg::ST_IDLE);
  assign ppb     = !fill_q;

  //////////////////////////////////////////////////////////////////////////
  // Control bits, writable only while idle
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fill_q  <= 1'b0;
      keep_q  <= 1'b0;
      multi_q <= 1'b0;
    end else if (ctrl_wr && st_q == irc_pkg::ST_IDLE) begin
      fill_q  <= I_WDATA[irc_pkg::CTRL_FILL];
      keep_q  <= I_WDATA[irc_pkg::CTRL_KEEP];
      multi_q <= I_WDATA[irc_pkg::CTRL_MULTI];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer: fetch, run, interrupt handling
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q         <= irc_pkg::ST_IDLE;
      evt_q        <= irc_pkg::EVT_RST;
      cur_q        <= '0;
      err_addr_q   <= irc_pkg::CMDPTR_RST;
      O_FETCH_REQ  <= 1'b0;
      O_FETCH_ADDR <= irc_pkg::CMDPTR_RST;
    end else begin
      O_FETCH_REQ <= 1'b0;
      case (st_q)
        irc_pkg::ST_IDLE: begin
          if (start) begin
            if (I_WDATA[irc_pkg::CTRL_MULTI] &&
                !(I_WDATA[irc_pkg::CTRL_FILL] &&
                  I_WDATA[irc_pkg::CTRL_KEEP])) begin
              evt_q      <= irc_pkg::EVT_UNKNOWN;
              err_addr_q <= cmdptr_q;
              st_q       <= irc_pkg::ST_I1;
            end else begin
              O_FETCH_REQ  <= 1'b1;
              O_FETCH_ADDR <= cmdptr_q;
              st_q         <= irc_pkg::ST_FETCH;
            end
          end
        end
        irc_pkg::ST_FETCH: begin
          if (I_FETCH_ERR) begin
            evt_q      <= irc_pkg::EVT_DESC_READ;
            err_addr_q <= O_FETCH_ADDR;
            st_q       <= irc_pkg::ST_I1;
          end else if (I_DESC_VALID) begin
            cur_q <= I_DESC;
            st_q  <= irc_pkg::ST_RUN;
          end
        end
        irc_pkg::ST_RUN: begin
          err_addr_q <= cur_q.addr;
          if (I_WR_ERR) begin
            evt_q <= irc_pkg::EVT_DATA_WRITE;
            st_q  <= irc_pkg::ST_I1;
          end else if (I_FIFO_FULL) begin
            evt_q <= irc_pkg::EVT_OVERRUN;
            st_q  <= irc_pkg::ST_I1;
          end else if (I_PROG_ERR) begin
            evt_q <= irc_pkg::EVT_UNKNOWN;
            st_q  <= irc_pkg::ST_I1;
          end else if (I_PKT_DONE) begin
            evt_q <= I_PKT_BAD ? irc_pkg::EVT_DATA_ERR
                               : irc_pkg::EVT_COMPLETE;
            // Whole packet in a more-input ends the program here
            if (ppb || I_PKT_BAD)
              st_q <= irc_pkg::ST_I1;
          end else if (I_BUF_EMPTY) begin
            if (!ppb) begin
              evt_q <= irc_pkg::EVT_COMPLETE;
              st_q  <= irc_pkg::ST_I1;
            end else if (cur_q.last) begin
              evt_q <= irc_pkg::EVT_LONG_PKT;
              st_q  <= irc_pkg::ST_I1;
            end else begin
              O_FETCH_REQ  <= 1'b1;
              O_FETCH_ADDR <= cur_q.addr + irc_pkg::DESC_STEP;
              st_q         <= irc_pkg::ST_FETCH;
            end
          end
        end
        irc_pkg::ST_I1: begin
          st_q <= evt_is_error(evt_q) ? irc_pkg::ST_I2
                                      : irc_pkg::ST_I3;
        end
        irc_pkg::ST_I2: begin
          st_q <= irc_pkg::ST_IDLE;
        end
        irc_pkg::ST_I3: begin
          if (cur_q.z == irc_pkg::BLOCK_END) begin
            st_q <= irc_pkg::ST_IDLE;
          end else begin
            O_FETCH_REQ  <= 1'b1;
            O_FETCH_ADDR <= cur_q.next_program_pointer;
            st_q         <= irc_pkg::ST_FETCH;
          end
        end
        default: st_q <= irc_pkg::ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Residual count follows the buffer in use
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      res_q <= 16'h0000;
    else if (st_q == irc_pkg::ST_RUN)
      res_q <= I_RES_CNT;
  end

  //////////////////////////////////////////////////////////////////////////
  // Event field and descriptor status write-back
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      evt_field_q <= irc_pkg::EVT_RST;
      O_STS_WR    <= 1'b0;
      O_STS       <= '0;
    end else begin
      O_STS_WR <= 1'b0;
      if (st_q == irc_pkg::ST_I1) begin
        evt_field_q <= evt_q;
        if (!ppb || cur_q.s) begin
          O_STS_WR <= 1'b1;
          O_STS.addr <= cur_q.addr;
          O_STS.transfer_status_field <= evt_q;
          O_STS.residual_count_field  <= res_q;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command pointer
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      cmdptr_q <= irc_pkg::CMDPTR_RST;
    else if (st_q == irc_pkg::ST_I2)
      cmdptr_q <= err_addr_q;
    else if (st_q == irc_pkg::ST_I3 && cur_q.z != irc_pkg::BLOCK_END)
      cmdptr_q <= cur_q.next_program_pointer;
    else if (I_WR && I_ADDR == irc_pkg::REG_CMDPTR &&
             st_q == irc_pkg::ST_IDLE)
      cmdptr_q <= I_WDATA[31:4];
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt event bits: write one to clear, set wins
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      int_q <= 2'h0;
    end else begin
      int_q[irc_pkg::INT_CTX] <=
        (st_q == irc_pkg::ST_I3 && cur_q.i == irc_pkg::IFLAG_ALWAYS) ||
        (int_q[irc_pkg::INT_CTX] &&
         !(I_WR && I_ADDR == irc_pkg::REG_INTEV &&
           I_WDATA[irc_pkg::INT_CTX]));
      int_q[irc_pkg::INT_FATAL] <=
        (st_q == irc_pkg::ST_I2 && cur_q.i == irc_pkg::IFLAG_ALWAYS) ||
        (int_q[irc_pkg::INT_FATAL] &&
         !(I_WR && I_ADDR == irc_pkg::REG_INTEV &&
           I_WDATA[irc_pkg::INT_FATAL]));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Stream controls and header capture
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_STRIP      <= 1'b0;
      O_ALIGN      <= 1'b0;
      O_ACTIVE     <= 1'b0;
      O_INT_EVENTS <= 2'h0;
      O_HDR        <= '0;
    end else begin
      O_STRIP      <= !keep_q;
      O_ALIGN      <= !keep_q || (ppb && I_HDR_SPLIT);
      O_ACTIVE     <= (st_q != irc_pkg::ST_IDLE);
      O_INT_EVENTS <= int_q;
      if (I_HDR_VALID)
        O_HDR <= irc_pkg::irc_hdr_t'(I_HDR);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register read, data in the next cycle
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RDATA <= 32'h00000000;
    end else if (I_RD) begin
      case (I_ADDR)
        irc_pkg::REG_CTRL:
          O_RDATA <= {16'h0000, (st_q != irc_pkg::ST_IDLE), 2'h0,
                      evt_field_q, 4'h0, multi_q, keep_q, fill_q,
                      (st_q != irc_pkg::ST_IDLE)};
        irc_pkg::REG_CMDPTR: O_RDATA <= {cmdptr_q, 4'h0};
        irc_pkg::REG_INTEV:  O_RDATA <= {30'h00000000, int_q};
        default:             O_RDATA <= 32'h00000000;
      endcase
    end else begin
      O_RDATA <= 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  property p_fetch_err;
    st_q == irc_pkg::ST_FETCH && I_FETCH_ERR |=>
      evt_q == irc_pkg::EVT_DESC_READ ##1 st_q == irc_pkg::ST_I2;
  endproperty
  a_fetch_err: assert property (p_fetch_err)
    else $error("fetch error not reported as 06h");

  property p_multi_bad;
    start && I_WDATA[irc_pkg::CTRL_MULTI] &&
    !(I_WDATA[irc_pkg::CTRL_FILL] && I_WDATA[irc_pkg::CTRL_KEEP]) |=>
      evt_q == irc_pkg::EVT_UNKNOWN && st_q == irc_pkg::ST_I1;
  endproperty
  a_multi_bad: assert property (p_multi_bad)
    else $error("bad multi-channel mode not reported");

  property p_wr_err;
    st_q == irc_pkg::ST_RUN && I_WR_ERR |=>
      evt_q == irc_pkg::EVT_DATA_WRITE && st_q == irc_pkg::ST_I1;
  endproperty
  a_wr_err: assert property (p_wr_err)
    else $error("data write error not reported");

  property p_overrun;
    st_q == irc_pkg::ST_RUN && !I_WR_ERR && I_FIFO_FULL |=>
      evt_q == irc_pkg::EVT_OVERRUN;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not reported");

  property p_long;
    st_q == irc_pkg::ST_RUN && ppb && cur_q.last && I_BUF_EMPTY &&
    !I_WR_ERR && !I_FIFO_FULL && !I_PROG_ERR && !I_PKT_DONE |=>
      evt_q == irc_pkg::EVT_LONG_PKT;
  endproperty
  a_long: assert property (p_long)
    else $error("long packet not reported");

  property p_evt_field;
    st_q == irc_pkg::ST_I1 |=> evt_field_q == $past(evt_q);
  endproperty
  a_evt_field: assert property (p_evt_field)
    else $error("event field not loaded");

  property p_sts_gate;
    st_q == irc_pkg::ST_I1 && ppb && !cur_q.s |=> !O_STS_WR;
  endproperty
  a_sts_gate: assert property (p_sts_gate)
    else $error("status written without s flag");

  property p_fatal;
    st_q == irc_pkg::ST_I2 && cur_q.i == irc_pkg::IFLAG_ALWAYS |=>
      int_q[irc_pkg::INT_FATAL] ##1 O_INT_EVENTS[irc_pkg::INT_FATAL];
  endproperty
  a_fatal: assert property (p_fatal)
    else $error("fatal flag not set");

  property p_branch;
    st_q == irc_pkg::ST_I3 && cur_q.z != irc_pkg::BLOCK_END |=>
      O_FETCH_REQ && cmdptr_q == $past(cur_q.next_program_pointer);
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch not taken");

  c_complete: cover property (st_q == irc_pkg::ST_I3 ##1
                              st_q == irc_pkg::ST_FETCH);
  c_error:    cover property (st_q == irc_pkg::ST_I2);
  c_long:     cover property (evt_q == irc_pkg::EVT_LONG_PKT &&
                              st_q == irc_pkg::ST_I1);

endmodule : irc_completion

// File: bench/irc_host_mem.sv
`timescale 1ns/1ps
module irc_host_mem (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Fetch request
  input  wire logic          fetch_req,
  input  wire logic [27:0]   fetch_addr,
  input  wire logic [3:0]    lat,
  input  wire logic          fail,
  // Fetch answer
  output logic               desc_valid,
  output logic               fetch_err,
  output irc_pkg::irc_desc_t desc
);
  irc_pkg::irc_desc_t mem [16];
  logic [27:0]        addr_q;
  int                 wait_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      desc_valid <= 1'b0;
      fetch_err  <= 1'b0;
      desc       <= '0;
      addr_q     <= '0;
      wait_q     <= -1;
    end else begin
      desc_valid <= 1'b0;
      fetch_err  <= 1'b0;
      // Released bus changes every cycle
      desc       <= irc_pkg::irc_desc_t'(~desc);
      if (fetch_req) begin
        addr_q <= fetch_addr;
        wait_q <= int'(lat);
      end else if (wait_q == 0) begin
        wait_q <= -1;
        if (fail)
          fetch_err <= 1'b1;
        else begin
          desc_valid <= 1'b1;
          desc       <= mem[addr_q[3:0]];
        end
      end else if (wait_q > 0) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule : irc_host_mem

// File: bench/tb_iso_receive_context_completion.sv
`timescale 1ns/1ps
module tb_iso_receive_context_completion;
  logic               clk, rst_n, wr_s, rd_s, split, hdr_v, bad;
  logic               fail, loose, dv, ferr, freq, sts_wr;
  logic               strip, align, active;
  logic               rd_pend = 1'b0;
  logic [3:0]         addr, lat;
  logic [4:0]         evs;
  logic [4:0]         codes [3];
  logic [15:0]        res;
  logic [31:0]        wdata, rdata, hdr, h;
  logic [27:0]        faddr;
  logic [2:0]         m;
  logic [1:0]         ints;
  irc_pkg::irc_desc_t desc;
  irc_pkg::irc_sts_t  sts;
  irc_pkg::irc_hdr_t  ohdr;
  irc_pkg::irc_sts_t  sts_q [$];
  logic [31:0]        rd_q [$];
  int                 num_errors, compares;

  irc_completion dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .O_FETCH_REQ(freq),
    .O_FETCH_ADDR(faddr), .I_FETCH_ERR(ferr), .I_DESC_VALID(dv),
    .I_DESC(desc), .I_PROG_ERR(evs[2]), .I_WR_ERR(evs[0]),
    .I_FIFO_FULL(evs[1]), .I_PKT_DONE(evs[3]), .I_PKT_BAD(bad),
    .I_BUF_EMPTY(evs[4]), .I_RES_CNT(res), .I_HDR_SPLIT(split),
    .I_HDR_VALID(hdr_v), .I_HDR(hdr), .O_STS_WR(sts_wr), .O_STS(sts),
    .O_HDR(ohdr), .O_STRIP(strip), .O_ALIGN(align), .O_ACTIVE(active),
    .O_INT_EVENTS(ints));

  irc_host_mem host (.clk(clk), .rst_n(rst_n), .fetch_req(freq),
    .fetch_addr(faddr), .lat(lat), .fail(fail), .desc_valid(dv),
    .fetch_err(ferr), .desc(desc));

  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk);
    rd_s <= 1'b0;
  endtask : rd

  function automatic logic [31:0] cv(input logic [4:0] c,
                                     input logic [3:0] md);
    cv = {19'h0, c, 4'h0, md & 4'hE};
  endfunction : cv

  function automatic irc_pkg::irc_desc_t mk(input logic [27:0] a,
      input logic l, input logic s, input logic [1:0] i,
      input logic [3:0] z, input logic [27:0] nx);
    mk = '{a, l, s, i, z, nx};
  endfunction : mk

  task automatic start(input logic [27:0] a, input logic [3:0] md);
    lat <= 4'($urandom_range(0, 5));
    wr(irc_pkg::REG_CMDPTR, {a, 4'h0});
    wr(irc_pkg::REG_CTRL, {28'h0, md});
  endtask : start

  // Waits for a descriptor if asked, then pulses one progress input
  task automatic fire(input logic [4:0] e, input logic b, input logic w,
                      input logic p, input logic [27:0] a,
                      input logic [4:0] c);
    int          n;
    logic [15:0] r;
    n = 0;
    r = 16'($urandom);
    while (w && !dv && n < 60) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    res <= r;
    if (p)
      sts_q.push_back('{a, c, r});
    @(posedge clk);
    evs <= e;
    bad <= b;
    @(posedge clk);
    evs <= '0;
    bad <= 1'b0;
  endtask : fire

  task automatic idle;
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    while (active && n < 200) begin
      @(posedge clk);
      n++;
    end
    check(active, 1'b0);
    repeat (2) @(posedge clk);
  endtask : idle

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rd_pend)
      check(rdata, rd_q.pop_front());
    rd_pend <= rd_s;
    if (sts_wr && sts_q.size() > 0)
      check(sts, sts_q.pop_front());
    else if (sts_wr && !loose)
      check(64'h1, 64'h0);
  end

  initial begin
    #80000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    clk = 1'b0; rst_n = 1'b0; wr_s = 1'b0; rd_s = 1'b0; addr = 4'h0;
    wdata = 32'h0; evs = 5'h00; bad = 1'b0; res = 16'h0000; split = 1'b0;
    hdr_v = 1'b0; hdr = 32'h0; fail = 1'b0; lat = 4'h0; loose = 1'b0;
    num_errors = 0;
    compares = 0;
    void'($urandom(39672));
    codes = '{irc_pkg::EVT_DATA_WRITE, irc_pkg::EVT_OVERRUN,
              irc_pkg::EVT_UNKNOWN};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 16; k += 4)
      rd(4'(k), 32'h0);
    $display("test reset done");
    host.mem[1] = mk(28'h1, 1'b1, 1'b1, 2'h3, 4'h2, 28'h2);
    host.mem[2] = mk(28'h2, 1'b1, 1'b1, 2'h0, 4'h0, 28'h0);
    start(28'h1, 4'h1);
    fire(5'h08, 1'b0, 1'b1, 1'b1, 28'h1, irc_pkg::EVT_COMPLETE);
    fire(5'h08, 1'b1, 1'b1, 1'b1, 28'h2, irc_pkg::EVT_DATA_ERR);
    idle();
    rd(irc_pkg::REG_CTRL, cv(irc_pkg::EVT_DATA_ERR, 4'h1));
    rd(irc_pkg::REG_INTEV, 32'h1);
    rd(irc_pkg::REG_CMDPTR, 32'h20);
    check(ints, 2'h1);
    wr(irc_pkg::REG_INTEV, 32'h3);
    host.mem[3] = mk(28'h3, 1'b1, 1'b0, 2'h0, 4'h0, 28'h0);
    start(28'h3, 4'h1);
    fire(5'h08, 1'b0, 1'b1, 1'b0, 28'h0, 5'h00);
    idle();
    rd(irc_pkg::REG_CTRL, cv(irc_pkg::EVT_COMPLETE, 4'h1));
    $display("test packet per buffer done");
    host.mem[4] = mk(28'h4, 1'b0, 1'b1, 2'h0, 4'h0, 28'h0);
    host.mem[5] = mk(28'h5, 1'b1, 1'b1, 2'h0, 4'h0, 28'h0);
    host.mem[6] = mk(28'h6, 1'b0, 1'b1, 2'h3, 4'h0, 28'h0);
    start(28'h4, 4'h1);
    fire(5'h10, 1'b0, 1'b1, 1'b0, 28'h0, 5'h00);
    fire(5'h10, 1'b0, 1'b1, 1'b1, 28'h5, irc_pkg::EVT_LONG_PKT);
    idle();
    start(28'h6, 4'h1);
    fire(5'h08, 1'b0, 1'b1, 1'b1, 28'h6, irc_pkg::EVT_COMPLETE);
    idle();
    rd(irc_pkg::REG_INTEV, 32'h1);
    wr(irc_pkg::REG_INTEV, 32'h3);
    $display("test chaining done");
    host.mem[7] = mk(28'h7, 1'b1, 1'b1, 2'h3, 4'h0, 28'h0);
    for (int j = 0; j < 3; j++) begin
      start(28'h7, 4'h1);
      fire(5'(1 << j), 1'b0, 1'b1, 1'b1, 28'h7, codes[j]);
      idle();
      rd(irc_pkg::REG_CTRL, cv(codes[j], 4'h1));
      rd(irc_pkg::REG_INTEV, 32'h2);
      rd(irc_pkg::REG_CMDPTR, 32'h70);
      wr(irc_pkg::REG_INTEV, 32'h3);
    end
    fail <= 1'b1;
    loose <= 1'b1;
    start(28'h8, 4'h1);
    idle();
    rd(irc_pkg::REG_CTRL, cv(irc_pkg::EVT_DESC_READ, 4'h1));
    rd(irc_pkg::REG_CMDPTR, 32'h80);
    fail <= 1'b0;
    start(28'h8, 4'hD);
    idle();
    rd(irc_pkg::REG_CTRL, cv(irc_pkg::EVT_UNKNOWN, 4'hD));
    start(28'h8, 4'hB);
    idle();
    rd(irc_pkg::REG_CTRL, cv(irc_pkg::EVT_UNKNOWN, 4'hB));
    wr(irc_pkg::REG_INTEV, 32'h3);
    loose <= 1'b0;
    $display("test errors done");
    host.mem[9] = mk(28'h9, 1'b1, 1'b0, 2'h0, 4'h0, 28'h0);
    start(28'h9, 4'h7);
    fire(5'h08, 1'b0, 1'b1, 1'b0, 28'h0, 5'h00);
    h = $urandom;
    hdr <= h;
    hdr_v <= 1'b1;
    @(posedge clk);
    hdr_v <= 1'b0;
    @(posedge clk);
    check(ohdr, h);
    fire(5'h10, 1'b0, 1'b0, 1'b1, 28'h9, irc_pkg::EVT_COMPLETE);
    idle();
    $display("test buffer fill done");
    for (int k = 0; k < 8; k++) begin
      m = 3'(k);
      split <= m[0];
      wr(irc_pkg::REG_CTRL, {28'h0, 1'b0, m[2], m[1], 1'b0});
      repeat (3) @(posedge clk);
      check(strip, !m[2]);
      check(align, !m[2] | (!m[1] & m[0]));
    end
    $display("test strip and align done");
    repeat (4) @(posedge clk);
    check(sts_q.size(), 64'h0);
    tally_and_finish();
  end
endmodule : tb_iso_receive_context_completion
